// ---- design/erc_pkg.sv ----
// Shared constants for the endpoint 0 receive control block
package erc_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] ERC_OFS_BYTE_COUNT = 8'h00;
  localparam logic [7:0] ERC_OFS_CONTROL = 8'h04;
  localparam logic [7:0] ERC_OFS_STATUS = 8'h08;
  localparam logic [7:0] ERC_OFS_FLAGS = 8'h0c;

  // ==========================================================
  // Control register fields
  localparam int ERC_CTL_CLEAR_BIT = 7;
  localparam int ERC_CTL_STALL_BIT = 3;
  localparam int ERC_CTL_FEN_BIT = 1;
  localparam int ERC_CTL_EN_BIT = 0;
  localparam logic [7:0] ERC_CTL_RESET = 8'h00;
  localparam logic [3:0] ERC_COUNT_RESET = 4'h0;

  // ==========================================================
  // Status and flag fields
  localparam int ERC_STS_ACK_BIT = 0;
  localparam int ERC_FLG_EMPTY_BIT = 3;
  localparam int ERC_FLG_FULL_BIT = 2;
  localparam int ERC_FLG_UNDER_BIT = 1;
  localparam int ERC_FLG_OVER_BIT = 0;

  // ==========================================================
  // Geometry and timing
  localparam int ERC_FIFO_DEPTH = 8;
  localparam int ERC_CLEAR_CYCLES = 2;

  // ==========================================================
  // Handshake answer codes
  localparam logic [1:0] ERC_HS_NONE = 2'h0;
  localparam logic [1:0] ERC_HS_ACK = 2'h1;
  localparam logic [1:0] ERC_HS_NACK = 2'h2;
  localparam logic [1:0] ERC_HS_STALL = 2'h3;

endpackage

// ---- design/erc_rx_fifo_flags.sv ----
// Receive FIFO level tracking, flags and pointer reset sequencer
`timescale 1ns/1ps
module erc_rx_fifo_flags #(
  parameter int DEPTH = erc_pkg::ERC_FIFO_DEPTH,
  parameter int CLEAR_CYCLES = erc_pkg::ERC_CLEAR_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic push,
  input wire logic pop,
  input wire logic clear_req,
  output logic clear_done,
  output logic empty,
  output logic full,
  output logic underrun,
  output logic overrun
);
  import erc_pkg::*;

  localparam int LW = $clog2(DEPTH + 1);
  localparam int CW = $clog2(CLEAR_CYCLES + 1);
  localparam logic [LW-1:0] LVL_MAX = LW'(DEPTH);
  localparam logic [CW-1:0] CNT_LAST = CW'(CLEAR_CYCLES - 1);

  typedef enum logic [1:0] {
    ERC_FS_IDLE = 2'b01,
    ERC_FS_CLEAR = 2'b10
  } erc_fstate_e;

  typedef struct packed {
    erc_fstate_e st;
    logic [CW-1:0] cnt;
    logic [LW-1:0] level;
    logic empty;
    logic full;
    logic under;
    logic over;
    logic done;
  } erc_fifo_s;

  erc_fifo_s state_r;
  erc_fifo_s state_nxt;

  always_comb begin
    state_nxt = state_r;
    state_nxt.done = 1'b0;
    unique case (state_r.st)
      ERC_FS_IDLE: begin
        if (clear_req) begin
          state_nxt.st = ERC_FS_CLEAR;
          state_nxt.cnt = '0;
        end else begin
          if (push && !pop) begin
            if (state_r.level == LVL_MAX) begin
              state_nxt.over = 1'b1;
            end else begin
              state_nxt.level = state_r.level + LW'(1);
            end
          end else if (pop && !push) begin
            if (state_r.level == '0) begin
              state_nxt.under = 1'b1;
            end else begin
              state_nxt.level = state_r.level - LW'(1);
            end
          end
          state_nxt.empty = (state_nxt.level == '0);
          state_nxt.full = (state_nxt.level == LVL_MAX);
        end
      end
      ERC_FS_CLEAR: begin
        // Pointers held at zero while the reset runs
        state_nxt.level = '0;
        if (state_r.cnt == CNT_LAST) begin
          state_nxt.st = ERC_FS_IDLE;
          state_nxt.done = 1'b1;
          state_nxt.empty = 1'b1;
          state_nxt.full = 1'b0;
          state_nxt.under = 1'b0;
          state_nxt.over = 1'b0;
        end else begin
          state_nxt.cnt = state_r.cnt + CW'(1);
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= '{st: ERC_FS_IDLE, cnt: '0, level: '0, empty: 1'b1, full: 1'b0,
                   under: 1'b0, over: 1'b0, done: 1'b0};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign clear_done = state_r.done;
  assign empty = state_r.empty;
  assign full = state_r.full;
  assign underrun = state_r.under;
  assign overrun = state_r.over;

endmodule // erc_rx_fifo_flags

// ---- design/erc_ep0_rx_ctrl.sv ----
// Endpoint 0 receive control, byte count and handshake decision
// Summary of operation
// - Load byte count after valid setup or acknowledged OUT
// - Reading FIFO never changes byte count
// - Byte count read-only, zero after reset
// - Clear bit resets FIFO, self-clears when done
// - Clear completion sets empty, clears other flags
// - Stall bit stalls next valid OUT
// - Setup always accepted unless packet error
// - Successful setup clears stall bit
// - FIFO enable accepts next valid OUT
// - FIFO enable clears when ACK status sets
// - FIFO enable clears on setup or clear
// - OUT without enable NACKs, stall overrides
// - Connect only with receive and transmit enabled
// - Control bits read/write except clear bit (writing 0 has no effect), cleared by reset
// - Reserved bits carry no function, read zero
// - ACK status sets on acknowledged OUT, raises event
`timescale 1ns/1ps
module erc_ep0_rx_ctrl #(
  parameter int DEPTH = erc_pkg::ERC_FIFO_DEPTH,
  parameter int CLEAR_CYCLES = erc_pkg::ERC_CLEAR_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic txn_valid,
  input wire logic txn_is_setup,
  input wire logic txn_data_ok,
  input wire logic [3:0] txn_byte_count,
  input wire logic fifo_push,
  input wire logic fifo_pop,
  input wire logic tx_endpoint_enable,
  output logic hs_valid,
  output logic [1:0] hs_code,
  output logic rx_ack_event,
  output logic function_connect,
  output logic rx_fifo_empty_flag,
  output logic rx_fifo_full_flag,
  output logic rx_fifo_underrun_flag,
  output logic rx_fifo_overrun_flag
);
  import erc_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic [3:0] rx_byte_count;
    logic rx_fifo_clear;
    logic rx_stall_request;
    logic rx_fifo_accept_enable;
    logic rx_endpoint_enable;
    logic ack_status;
    logic clear_pending;
    logic hs_valid;
    logic [1:0] hs_code;
    logic connect;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } erc_state_s;

  erc_state_s state_r;
  erc_state_s state_nxt;

  logic clear_done;
  logic f_empty;
  logic f_full;
  logic f_under;
  logic f_over;
  logic acc;
  logic wr;
  logic mapped;
  logic [7:0] ctl_rd;
  logic [31:0] rd_mux;

  // ==========================================================
  // FIFO pointer and flag tracker
  erc_rx_fifo_flags #(
    .DEPTH(DEPTH),
    .CLEAR_CYCLES(CLEAR_CYCLES)
  ) u_flags (
    .pclk(pclk),
    .presetn(presetn),
    .push(fifo_push),
    .pop(fifo_pop),
    .clear_req(state_r.rx_fifo_clear && !state_r.clear_pending),
    .clear_done(clear_done),
    .empty(f_empty),
    .full(f_full),
    .underrun(f_under),
    .overrun(f_over)
  );

  // ==========================================================
  // APB decode
  always_comb begin
    acc = psel && penable && state_r.pready;
    wr = acc && pwrite;
    mapped = (paddr == ERC_OFS_BYTE_COUNT) || (paddr == ERC_OFS_CONTROL) ||
             (paddr == ERC_OFS_STATUS) || (paddr == ERC_OFS_FLAGS);
    ctl_rd = 8'h00;
    ctl_rd[ERC_CTL_CLEAR_BIT] = state_r.rx_fifo_clear;
    ctl_rd[ERC_CTL_STALL_BIT] = state_r.rx_stall_request;
    ctl_rd[ERC_CTL_FEN_BIT] = state_r.rx_fifo_accept_enable;
    ctl_rd[ERC_CTL_EN_BIT] = state_r.rx_endpoint_enable;
    rd_mux = 32'h0000_0000;
    if (paddr == ERC_OFS_BYTE_COUNT) begin
      rd_mux[3:0] = state_r.rx_byte_count;
    end else if (paddr == ERC_OFS_CONTROL) begin
      rd_mux[7:0] = ctl_rd;
    end else if (paddr == ERC_OFS_STATUS) begin
      rd_mux[ERC_STS_ACK_BIT] = state_r.ack_status;
    end else if (paddr == ERC_OFS_FLAGS) begin
      rd_mux[ERC_FLG_EMPTY_BIT] = f_empty;
      rd_mux[ERC_FLG_FULL_BIT] = f_full;
      rd_mux[ERC_FLG_UNDER_BIT] = f_under;
      rd_mux[ERC_FLG_OVER_BIT] = f_over;
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    state_nxt = state_r;
    state_nxt.hs_valid = 1'b0;
    state_nxt.hs_code = ERC_HS_NONE;
    // One wait state: pready rises on the second access cycle
    state_nxt.pready = psel && penable && !state_r.pready;
    if (psel && penable && !state_r.pready) begin
      state_nxt.prdata = pwrite ? 32'h0000_0000 : rd_mux;
      state_nxt.pslverr = !mapped;
    end else if (!psel) begin
      state_nxt.pslverr = 1'b0;
    end

    // Software writes first, so hardware events below win
    if (wr && paddr == ERC_OFS_CONTROL) begin
      state_nxt.rx_fifo_clear = pwdata[ERC_CTL_CLEAR_BIT] ||
                                state_r.rx_fifo_clear;
      state_nxt.rx_stall_request = pwdata[ERC_CTL_STALL_BIT];
      state_nxt.rx_fifo_accept_enable = pwdata[ERC_CTL_FEN_BIT];
      state_nxt.rx_endpoint_enable = pwdata[ERC_CTL_EN_BIT];
      if (pwdata[ERC_CTL_CLEAR_BIT]) begin
        state_nxt.rx_fifo_accept_enable = 1'b0;
      end
    end
    if (wr && paddr == ERC_OFS_STATUS && pwdata[ERC_STS_ACK_BIT]) begin
      state_nxt.ack_status = 1'b0;
    end

    // Clear request handed to the tracker once
    if (state_r.rx_fifo_clear && !state_r.clear_pending) begin
      state_nxt.clear_pending = 1'b1;
    end
    if (clear_done) begin
      state_nxt.rx_fifo_clear = 1'b0;
      state_nxt.clear_pending = 1'b0;
    end
    if (state_r.rx_fifo_clear) begin
      state_nxt.rx_fifo_accept_enable = 1'b0;
    end

    // Transaction outcome; FIFO reads never touch the count
    if (txn_valid && txn_data_ok) begin
      state_nxt.hs_valid = 1'b1;
      if (txn_is_setup) begin
        state_nxt.hs_code = ERC_HS_ACK;
        state_nxt.rx_byte_count = txn_byte_count;
        state_nxt.rx_stall_request = 1'b0;
        state_nxt.rx_fifo_accept_enable = 1'b0;
        state_nxt.ack_status = 1'b0;
      end else if (state_r.rx_stall_request) begin
        state_nxt.hs_code = ERC_HS_STALL;
      end else if (!state_r.rx_fifo_accept_enable) begin
        state_nxt.hs_code = ERC_HS_NACK;
      end else begin
        state_nxt.hs_code = ERC_HS_ACK;
        state_nxt.rx_byte_count = txn_byte_count;
        state_nxt.ack_status = 1'b1;
        state_nxt.rx_fifo_accept_enable = 1'b0;
      end
    end

    state_nxt.connect = state_r.rx_endpoint_enable && tx_endpoint_enable;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= '{rx_byte_count: ERC_COUNT_RESET,
                   rx_fifo_clear: ERC_CTL_RESET[ERC_CTL_CLEAR_BIT],
                   rx_stall_request: ERC_CTL_RESET[ERC_CTL_STALL_BIT],
                   rx_fifo_accept_enable: ERC_CTL_RESET[ERC_CTL_FEN_BIT],
                   rx_endpoint_enable: ERC_CTL_RESET[ERC_CTL_EN_BIT],
                   ack_status: 1'b0, clear_pending: 1'b0, hs_valid: 1'b0,
                   hs_code: ERC_HS_NONE, connect: 1'b0, pready: 1'b0,
                   pslverr: 1'b0, prdata: 32'h0000_0000};
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign prdata = state_r.prdata;
  assign pready = state_r.pready;
  assign pslverr = state_r.pslverr;
  assign hs_valid = state_r.hs_valid;
  assign hs_code = state_r.hs_code;
  assign rx_ack_event = state_r.ack_status;
  assign function_connect = state_r.connect;
  assign rx_fifo_empty_flag = f_empty;
  assign rx_fifo_full_flag = f_full;
  assign rx_fifo_underrun_flag = f_under;
  assign rx_fifo_overrun_flag = f_over;

endmodule // erc_ep0_rx_ctrl

// ---- verif/erc_ep0_rx_monitor.sv ----
// Port checker for the endpoint 0 receive control block
`timescale 1ns/1ps
module erc_ep0_rx_monitor (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic [7:0] paddr,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic txn_valid,
  input logic txn_is_setup,
  input logic txn_data_ok,
  input logic tx_endpoint_enable,
  input logic hs_valid,
  input logic [1:0] hs_code,
  input logic rx_ack_event,
  input logic function_connect,
  input logic rx_fifo_empty_flag,
  input logic rx_fifo_full_flag
);
  import erc_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Sequences
  sequence apb_setup_s;
    psel && !penable;
  endsequence
  sequence good_txn_s;
    txn_valid && txn_data_ok;
  endsequence
  // ==========================================================
  // Properties
  apb_wait_a: assert property (apb_setup_s |-> ##1 !pready ##1 pready)
    else $error("pready not two cycles after setup");
  unmapped_err_a: assert property (apb_setup_s and paddr > 8'h0c |-> ##2 pslverr)
    else $error("unmapped access without pslverr");
  upper_zero_a: assert property (pready && !pslverr |-> prdata[31:8] == 24'h0)
    else $error("reserved read data not zero");
  hs_answer_a: assert property (good_txn_s |=> hs_valid)
    else $error("no handshake after good transaction");
  bad_quiet_a: assert property (txn_valid && !txn_data_ok |=> !hs_valid)
    else $error("handshake after bad packet");
  setup_ack_a: assert property (good_txn_s and txn_is_setup |=> hs_code == ERC_HS_ACK)
    else $error("setup not acknowledged");
  ack_cause_a: assert property ($rose(rx_ack_event) |-> hs_valid && hs_code == ERC_HS_ACK)
    else $error("ack event without ack handshake");
  connect_a: assert property (!tx_endpoint_enable |=> !function_connect)
    else $error("connected without transmit enable");
  empty_full_a: assert property (rx_fifo_empty_flag |-> !rx_fifo_full_flag)
    else $error("fifo empty and full together");
  hs_code_a: assert property (hs_valid |-> hs_code != ERC_HS_NONE)
    else $error("handshake pulse without code");
  setup_ack_clr_a: assert property (good_txn_s and txn_is_setup |=> !rx_ack_event)
    else $error("ack event survives setup");
endmodule // erc_ep0_rx_monitor

bind erc_ep0_rx_ctrl erc_ep0_rx_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .txn_valid(txn_valid), .txn_is_setup(txn_is_setup), .txn_data_ok(txn_data_ok),
  .tx_endpoint_enable(tx_endpoint_enable), .hs_valid(hs_valid), .hs_code(hs_code),
  .rx_ack_event(rx_ack_event), .function_connect(function_connect),
  .rx_fifo_empty_flag(rx_fifo_empty_flag), .rx_fifo_full_flag(rx_fifo_full_flag));

// ---- verif/erc_host_model.sv ----
// Serial engine side model issuing setup and OUT transactions
`timescale 1ns/1ps
module erc_host_model (
  input logic pclk,
  output logic txn_valid,
  output logic txn_is_setup,
  output logic txn_data_ok,
  output logic [3:0] txn_byte_count,
  output logic fifo_push,
  input logic hs_valid,
  input logic [1:0] hs_code
);
  import erc_pkg::*;
  initial begin
    txn_valid = 0;
    txn_is_setup = 0;
    txn_data_ok = 0;
    txn_byte_count = 4'h0;
    fifo_push = 0;
  end
  // Push pn bytes, end the transaction, then catch the handshake
  task automatic send(input logic s, input logic ok, input logic [3:0] n, input int pn,
    output logic [1:0] code);
    int i;
    for (i = 0; i < pn; i++) begin
      @(posedge pclk);
      fifo_push <= 1;
    end
    @(posedge pclk);
    fifo_push <= 0;
    txn_valid <= 1;
    txn_is_setup <= s;
    txn_data_ok <= ok;
    txn_byte_count <= n;
    @(posedge pclk);
    txn_valid <= 0;
    txn_is_setup <= !s;
    txn_data_ok <= !ok;
    txn_byte_count <= ~n;
    code = ERC_HS_NONE;
    repeat (2) begin
      @(posedge pclk);
      if (hs_valid === 1'b1) code = hs_code;
    end
  endtask
endmodule // erc_host_model

// ---- verif/tb_erc_ep0_rx_ctrl.sv ----
// Testbench for the endpoint 0 receive control block
`timescale 1ns/1ps
module tb_erc_ep0_rx_ctrl;
  import erc_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic fifo_pop = 0, tx_endpoint_enable = 0, ev;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic pready, pslverr, txn_valid, txn_is_setup, txn_data_ok, fifo_push;
  logic hs_valid, rx_ack_event, function_connect, fe, ff, fu, fo;
  logic [3:0] txn_byte_count;
  logic [1:0] hs_code, hc;
  int err_count = 0, checks_done = 0;
  always #20 pclk = ~pclk;
  erc_ep0_rx_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .txn_valid(txn_valid), .txn_is_setup(txn_is_setup),
    .txn_data_ok(txn_data_ok), .txn_byte_count(txn_byte_count), .fifo_push(fifo_push),
    .fifo_pop(fifo_pop), .tx_endpoint_enable(tx_endpoint_enable), .hs_valid(hs_valid),
    .hs_code(hs_code), .rx_ack_event(rx_ack_event), .function_connect(function_connect),
    .rx_fifo_empty_flag(fe), .rx_fifo_full_flag(ff), .rx_fifo_underrun_flag(fu),
    .rx_fifo_overrun_flag(fo));
  erc_host_model host (.pclk(pclk), .txn_valid(txn_valid), .txn_is_setup(txn_is_setup),
    .txn_data_ok(txn_data_ok), .txn_byte_count(txn_byte_count), .fifo_push(fifo_push),
    .hs_valid(hs_valid), .hs_code(hs_code));
  // ==========================================================
  // Shared tasks
  task automatic summarize;
    $display("Mismatches %0d of %0d checks", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rv = prdata;
    ev = pslverr;
    psel <= 0;
    penable <= 0;
    if (n >= 20) chk("pready", 0, 1);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(0, a, 32'h0);
    chk(nm, rv, exp);
  endtask
  task automatic tx(input logic s, input logic ok, input logic [3:0] n, input int pn,
    input logic [1:0] exp);
    host.send(s, ok, n, pn, hc);
    chk("handshake", {30'h0, hc}, {30'h0, exp});
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs;
    rd("count", ERC_OFS_BYTE_COUNT, 32'h0);
    rd("control", ERC_OFS_CONTROL, 32'h0);
    rd("flags", ERC_OFS_FLAGS, 32'h8);
    apb(1, ERC_OFS_CONTROL, 32'hff79);
    rd("control", ERC_OFS_CONTROL, 32'h9);
    apb(1, ERC_OFS_BYTE_COUNT, 32'hf);
    rd("count", ERC_OFS_BYTE_COUNT, 32'h0);
    apb(0, 8'h10, 32'h0);
    chk("slverr", ev, 1);
  endtask
  task automatic t_refuse;
    apb(1, ERC_OFS_CONTROL, 32'h1);
    tx(0, 1, 3, 0, ERC_HS_NACK);
    rd("count", ERC_OFS_BYTE_COUNT, 32'h0);
    apb(1, ERC_OFS_CONTROL, 32'h9);
    tx(0, 1, 3, 0, ERC_HS_STALL);
    apb(1, ERC_OFS_CONTROL, 32'hb);
    tx(0, 1, 3, 0, ERC_HS_STALL);
    tx(1, 0, 4, 0, ERC_HS_NONE);
    rd("control", ERC_OFS_CONTROL, 32'hb);
    tx(1, 1, 8, 8, ERC_HS_ACK);
    rd("control", ERC_OFS_CONTROL, 32'h1);
    rd("count", ERC_OFS_BYTE_COUNT, 32'h8);
  endtask
  task automatic t_clear;
    int i;
    tx(1, 1, 1, 1, ERC_HS_ACK);
    rd("flags", ERC_OFS_FLAGS, 32'h5);
    chk("flag pins", {fe, ff, fu, fo}, 4'h5);
    apb(1, ERC_OFS_CONTROL, 32'h83);
    apb(0, ERC_OFS_CONTROL, 32'h0);
    chk("accept", rv[1], 0);
    for (i = 0; i < 10 && rv[7] !== 1'b0; i++) apb(0, ERC_OFS_CONTROL, 32'h0);
    chk("clear bit", rv[7], 0);
    rd("flags", ERC_OFS_FLAGS, 32'h8);
    chk("flag pins", {fe, ff, fu, fo}, 4'h8);
  endtask
  task automatic t_accept;
    apb(1, ERC_OFS_CONTROL, 32'h3);
    tx(0, 1, 5, 5, ERC_HS_ACK);
    rd("control", ERC_OFS_CONTROL, 32'h1);
    rd("status", ERC_OFS_STATUS, 32'h1);
    chk("ack event", rx_ack_event, 1);
    repeat (6) begin
      @(posedge pclk);
      fifo_pop <= 1;
    end
    @(posedge pclk);
    fifo_pop <= 0;
    rd("count", ERC_OFS_BYTE_COUNT, 32'h5);
    rd("flags", ERC_OFS_FLAGS, 32'ha);
    chk("flag pins", {fe, ff, fu, fo}, 4'ha);
    apb(1, ERC_OFS_STATUS, 32'h1);
    rd("status", ERC_OFS_STATUS, 32'h0);
    chk("ack event", rx_ack_event, 0);
    tx(0, 1, 2, 0, ERC_HS_NACK);
    rd("count", ERC_OFS_BYTE_COUNT, 32'h5);
  endtask
  task automatic t_connect;
    @(posedge pclk);
    tx_endpoint_enable <= 1;
    repeat (3) @(posedge pclk);
    chk("connect", function_connect, 1);
    apb(1, ERC_OFS_CONTROL, 32'h0);
    repeat (3) @(posedge pclk);
    chk("connect", function_connect, 0);
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    t_regs();
    t_refuse();
    t_clear();
    t_accept();
    t_connect();
    summarize();
  end
  initial begin
    repeat (5000) @(posedge pclk);
    err_count++;
    $display("[FAIL] watchdog expected finish seen timeout");
    summarize();
  end
endmodule // tb_erc_ep0_rx_ctrl
